/* File: common/port2_consts.svh */
`ifndef PORT2_CONSTS_SVH
`define PORT2_CONSTS_SVH

// register byte addresses on the apb slave
`define OFS_FUNCTION_SELECT 8'h00
`define OFS_DIRECTION 8'h04
`define OFS_OUTPUT_LATCH 8'h08
`define OFS_INPUT_VALUE 8'h0c
`define OFS_IRQ_ENABLE 8'h10
`define OFS_IRQ_FLAG 8'h14
`define OFS_EDGE_SELECT 8'h18
`define OFS_FUSE_STATUS 8'h1c

// reset values of the port registers
`define RST_FUNCTION_SELECT 8'h00
`define RST_DIRECTION 8'h00
`define RST_OUTPUT_LATCH 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_FLAG 8'h00
`define RST_EDGE_SELECT 8'h00

// port geometry
`define PORT_BITS 8
`define BONDED_BITS 6
`define BIT_AUX_CLOCK 0
`define BIT_ALT_CLOCK 1
`define BIT_COMPARATOR 2
`define BIT_COMPARE1 3
`define BIT_COMPARE2 4

// synchroniser refill count after reset before pin edges are believed
`define PIN_SETTLE_DONE 2'h3

// fuse status register fields
`define FUSE_ARMED_POS 0
`define FUSE_CHECKING_POS 1
`define FUSE_SENSE_POS 2

`endif

/* File: common/port2_pkg.sv */
package port2_pkg;

  // fuse check sequence after power-on reset
  typedef enum logic [1:0] {
    fuse_armed,
    fuse_checking,
    fuse_done
  } fuse_state_t;

  typedef logic [7:0] port_byte_t;

endpackage

/* File: rtl/fuse_check.sv */
`timescale 1ns/10ps
`default_nettype none

// fuse continuity check, armed once per power-on reset
module fuse_check
  import port2_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic test_port_access,
  input wire logic test_pin,
  input wire logic fuse_intact,
  output fuse_state_t state,
  output logic fuse_sense_en
);

  logic [1:0] synced;
  logic test_pin_s;
  logic fuse_intact_s;
  fuse_state_t next_state;

  // both levels come from outside the clock domain
  pin_sync #(.WIDTH(2)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async_in({fuse_intact, test_pin}),
    .sync_out(synced)
  );

  assign test_pin_s = synced[0];
  assign fuse_intact_s = synced[1];

  // only the first access after reset starts a check; later ones are ignored
  always_comb begin
    next_state = state;
    case (state)
      fuse_armed: begin
        if (test_port_access) begin
          next_state = fuse_checking;
        end
      end
      fuse_checking: begin
        if (!test_pin_s) begin
          next_state = fuse_done;
        end
      end
      fuse_done: begin
        next_state = fuse_done;
      end
      default: begin
        next_state = fuse_armed;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state <= fuse_armed;
      fuse_sense_en <= 1'b0;
    end else begin
      state <= next_state;
      // sense current flows only through an intact fuse while checking
      fuse_sense_en <= (next_state == fuse_checking) && fuse_intact_s;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/port2_pin_function_mux.sv */
// Summary of operation
// - bit 0 peripheral select drives the pin from the auxiliary clock, input unused
// - bit 1 peripheral select drives ground, pin input feeds timer alternate clock
// - bit 2 peripheral select drives comparator result, input feeds capture 0 source b
// - bit 3 peripheral select drives compare unit 1 output, input unused
// - bit 4 peripheral select drives compare unit 2 output, input unused
// - pin output enable always comes from the direction bit
// - unbonded bits 6 and 7 keep all register bits, ground output
// - flags of bits 6 and 7 change only by software writes
// - first test port access after reset starts fuse check, with sense current only while the fuse reads intact
// - test pin returned low ends fuse check and its sense current
`timescale 1ns/10ps
`default_nettype none

`include "port2_consts.svh"

module port2_pin_function_mux
  import port2_pkg::*;
#(
  parameter int PORT_WIDTH = `PORT_BITS,
  parameter int PIN_WIDTH = `BONDED_BITS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_WIDTH-1:0] pin_in,
  output logic [PIN_WIDTH-1:0] pin_out,
  output logic [PIN_WIDTH-1:0] pin_oe,
  input wire logic aux_clock,
  input wire logic comparator_result,
  input wire logic compare_unit1_output,
  input wire logic compare_unit2_output,
  output logic timer_alternate_clock_in,
  output logic capture0_source_b,
  output logic irq_request,
  input wire logic test_port_access,
  input wire logic test_pin,
  input wire logic fuse_intact,
  output logic fuse_sense_en
);

  // software visible port registers
  logic [PORT_WIDTH-1:0] port_function_select;
  logic [PORT_WIDTH-1:0] port_direction;
  logic [PORT_WIDTH-1:0] port_output_latch;
  logic [PORT_WIDTH-1:0] port_irq_enable;
  logic [PORT_WIDTH-1:0] port_irq_flag;
  logic [PORT_WIDTH-1:0] port_edge_select;

  // pin sampling
  logic [PIN_WIDTH-1:0] pin_sync_q;
  logic [PIN_WIDTH-1:0] pin_prev;
  logic [PORT_WIDTH-1:0] port_input_value;

  // edge detection
  logic [PIN_WIDTH-1:0] rise_seen;
  logic [PIN_WIDTH-1:0] fall_seen;
  logic [PORT_WIDTH-1:0] edge_event;
  logic [1:0] settle;
  logic edges_live;

  // peripheral output per bit
  logic [PORT_WIDTH-1:0] periph_out;
  logic [PORT_WIDTH-1:0] port_drive;

  // bus decode
  logic setup_phase;
  logic access_phase;
  logic write_strobe;
  logic byte0_written;
  logic hit_function_select;
  logic hit_direction;
  logic hit_output_latch;
  logic hit_input_value;
  logic hit_irq_enable;
  logic hit_irq_flag;
  logic hit_edge_select;
  logic hit_fuse_status;
  logic addr_mapped;
  logic [7:0] wr_byte;
  logic [31:0] read_mux;
  logic [PORT_WIDTH-1:0] next_irq_flag;

  // fuse check
  fuse_state_t fuse_state;
  logic [7:0] fuse_status;

  // pins come from outside the clock domain
  pin_sync #(.WIDTH(PIN_WIDTH)) u_pin_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(pin_in),
    .sync_out(pin_sync_q)
  );

  // fuse continuity check on the test port
  fuse_check u_fuse_check (
    .mclk(mclk),
    .nrst(nrst),
    .test_port_access(test_port_access),
    .test_pin(test_pin),
    .fuse_intact(fuse_intact),
    .state(fuse_state),
    .fuse_sense_en(fuse_sense_en)
  );

  // unbonded bits read as zero since nothing drives them
  assign port_input_value = {{(PORT_WIDTH-PIN_WIDTH){1'b0}}, pin_sync_q};

  // apb phase decode
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign write_strobe = access_phase && pwrite;
  assign byte0_written = write_strobe && pstrb[0];
  assign wr_byte = pwdata[7:0];

  // address decode, one aligned word per register
  assign hit_function_select = (paddr == `OFS_FUNCTION_SELECT);
  assign hit_direction = (paddr == `OFS_DIRECTION);
  assign hit_output_latch = (paddr == `OFS_OUTPUT_LATCH);
  assign hit_input_value = (paddr == `OFS_INPUT_VALUE);
  assign hit_irq_enable = (paddr == `OFS_IRQ_ENABLE);
  assign hit_irq_flag = (paddr == `OFS_IRQ_FLAG);
  assign hit_edge_select = (paddr == `OFS_EDGE_SELECT);
  assign hit_fuse_status = (paddr == `OFS_FUSE_STATUS);
  assign addr_mapped = hit_function_select || hit_direction || hit_output_latch ||
                       hit_input_value || hit_irq_enable || hit_irq_flag ||
                       hit_edge_select || hit_fuse_status;

  // fuse status shows the check sequence to software
  assign fuse_status = {5'h00,
                        fuse_sense_en,
                        (fuse_state == fuse_checking),
                        (fuse_state == fuse_armed)};

  // read selection; upper bits read zero
  assign read_mux =
    hit_function_select ? {24'h000000, port_function_select} :
    hit_direction ? {24'h000000, port_direction} :
    hit_output_latch ? {24'h000000, port_output_latch} :
    hit_input_value ? {24'h000000, port_input_value} :
    hit_irq_enable ? {24'h000000, port_irq_enable} :
    hit_irq_flag ? {24'h000000, port_irq_flag} :
    hit_edge_select ? {24'h000000, port_edge_select} :
    hit_fuse_status ? {24'h000000, fuse_status} :
    32'h00000000;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_mapped;

  // read data is captured during setup so the access phase sees a flop
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // plain read/write registers; only byte lane 0 carries data
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      port_function_select <= `RST_FUNCTION_SELECT;
      port_direction <= `RST_DIRECTION;
      port_output_latch <= `RST_OUTPUT_LATCH;
      port_irq_enable <= `RST_IRQ_ENABLE;
      port_edge_select <= `RST_EDGE_SELECT;
    end else if (byte0_written) begin
      if (hit_function_select) begin
        port_function_select <= wr_byte;
      end
      if (hit_direction) begin
        port_direction <= wr_byte;
      end
      if (hit_output_latch) begin
        port_output_latch <= wr_byte;
      end
      if (hit_irq_enable) begin
        port_irq_enable <= wr_byte;
      end
      if (hit_edge_select) begin
        port_edge_select <= wr_byte;
      end
    end
  end

  // previous synced level for edge detection
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync_q;
    end
  end

  // the synchroniser restarts from zero at reset, so a pin already high would
  // look like a rising edge; edges count only once the chain holds real levels
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      settle <= 2'h0;
    end else if (settle != `PIN_SETTLE_DONE) begin
      settle <= settle + 2'h1;
    end
  end

  assign edges_live = (settle == `PIN_SETTLE_DONE);

  // edge select clear picks rising, set picks falling
  assign rise_seen = {PIN_WIDTH{edges_live}} & pin_sync_q & ~pin_prev;
  assign fall_seen = {PIN_WIDTH{edges_live}} & ~pin_sync_q & pin_prev;
  assign edge_event = {{(PORT_WIDTH-PIN_WIDTH){1'b0}},
                       (rise_seen & ~port_edge_select[PIN_WIDTH-1:0]) |
                       (fall_seen & port_edge_select[PIN_WIDTH-1:0])};

  // a hardware edge wins over a software clear in the same cycle
  always_comb begin
    next_irq_flag = port_irq_flag;
    if (byte0_written && hit_irq_flag) begin
      next_irq_flag = wr_byte;
    end
    next_irq_flag = next_irq_flag | edge_event;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      port_irq_flag <= `RST_IRQ_FLAG;
    end else begin
      port_irq_flag <= next_irq_flag;
    end
  end

  // one request line while any enabled flag stands
  assign irq_request = |(port_irq_flag & port_irq_enable);

  // peripheral output of each bit; ground where none is attached
  always_comb begin
    periph_out = '0;
    periph_out[`BIT_AUX_CLOCK] = aux_clock;
    periph_out[`BIT_COMPARATOR] = comparator_result;
    periph_out[`BIT_COMPARE1] = compare_unit1_output;
    periph_out[`BIT_COMPARE2] = compare_unit2_output;
  end

  // the pin path stays combinational so the clock and timer edges pass undelayed
  assign port_drive = (port_function_select & periph_out) |
                      (~port_function_select & port_output_latch);
  assign pin_out = port_drive[PIN_WIDTH-1:0];

  // drivers are enabled by direction only, never by a peripheral
  assign pin_oe = port_direction[PIN_WIDTH-1:0];

  // inputs routed to the timer only while the bit is in peripheral use
  assign timer_alternate_clock_in =
    port_function_select[`BIT_ALT_CLOCK] && pin_sync_q[`BIT_ALT_CLOCK];
  assign capture0_source_b =
    port_function_select[`BIT_COMPARATOR] && pin_sync_q[`BIT_COMPARATOR];

endmodule

`default_nettype wire

/* File: sim/port2_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "port2_consts.svh"

module port2_chk #(
  parameter int PIN_WIDTH = 6
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [PIN_WIDTH-1:0] pin_out,
  input wire logic [PIN_WIDTH-1:0] pin_oe,
  input wire logic aux_clock,
  input wire logic comparator_result,
  input wire logic compare_unit1_output,
  input wire logic compare_unit2_output,
  input wire logic timer_alternate_clock_in,
  input wire logic capture0_source_b,
  input wire logic test_port_access,
  input wire logic test_pin,
  input wire logic fuse_sense_en
);
  logic [7:0] sel;
  logic [7:0] dir;
  logic [7:0] outl;
  wire logic wr = psel && penable && pwrite && pstrb[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // shadow of the steering registers, seen only through apb writes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sel <= 8'h00;
      dir <= 8'h00;
      outl <= 8'h00;
    end else if (wr) begin
      if (paddr == `OFS_FUNCTION_SELECT) sel <= pwdata[7:0];
      if (paddr == `OFS_DIRECTION) dir <= pwdata[7:0];
      if (paddr == `OFS_OUTPUT_LATCH) outl <= pwdata[7:0];
    end
  end

  sequence s_pin_quiet;
    (!test_pin && !test_port_access) [*3];
  endsequence
  property p_aux; sel[0] |-> pin_out[0] == aux_clock; endproperty
  property p_gnd; sel[1] |-> !pin_out[1]; endproperty
  property p_route;
    (timer_alternate_clock_in |-> sel[1]) and (capture0_source_b |-> sel[2]);
  endproperty
  property p_cmp; sel[2] |-> pin_out[2] == comparator_result; endproperty
  property p_c1; sel[3] |-> pin_out[3] == compare_unit1_output; endproperty
  property p_c2; sel[4] |-> pin_out[4] == compare_unit2_output; endproperty
  property p_oe; pin_oe == dir[PIN_WIDTH-1:0]; endproperty
  property p_latch; (~sel[PIN_WIDTH-1:0] & (pin_out ^ outl[PIN_WIDTH-1:0])) == '0; endproperty
  property p_fuse_on; $rose(fuse_sense_en) |-> $past(test_port_access); endproperty
  property p_fuse_off; s_pin_quiet |=> !fuse_sense_en; endproperty

  a_aux: assert property (p_aux) else $error("bit 0 not aux clock");
  a_gnd: assert property (p_gnd) else $error("bit 1 not ground");
  a_route: assert property (p_route) else $error("timer input routed");
  a_cmp: assert property (p_cmp) else $error("bit 2 not comparator");
  a_c1: assert property (p_c1) else $error("bit 3 not compare 1");
  a_c2: assert property (p_c2) else $error("bit 4 not compare 2");
  a_oe: assert property (p_oe) else $error("enable not direction");
  a_latch: assert property (p_latch) else $error("latch not on pin");
  a_fuse_on: assert property (p_fuse_on) else $error("sense without access");
  a_fuse_off: assert property (p_fuse_off) else $error("sense after pin low");
endmodule

bind port2_pin_function_mux port2_chk #(.PIN_WIDTH(PIN_WIDTH)) chk_i (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pin_out(pin_out), .pin_oe(pin_oe),
  .aux_clock(aux_clock), .comparator_result(comparator_result),
  .compare_unit1_output(compare_unit1_output), .compare_unit2_output(compare_unit2_output),
  .timer_alternate_clock_in(timer_alternate_clock_in), .capture0_source_b(capture0_source_b),
  .test_port_access(test_port_access), .test_pin(test_pin), .fuse_sense_en(fuse_sense_en)
);

`default_nettype wire

/* File: sim/port2_far.sv */
`timescale 1ns/10ps
`default_nettype none

module port2_far (
  input wire logic mclk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext,
  input wire logic sess,
  output logic [5:0] pin_in,
  output logic aux_clock,
  output logic comparator_result,
  output logic compare_unit1_output,
  output logic compare_unit2_output,
  output logic test_pin
);
  logic [2:0] t = 3'h0;

  // peripheral sources keep moving so a stuck mux shows up
  always @(posedge mclk) t <= t + 3'h1;
  assign aux_clock = t[0];
  assign comparator_result = t[1];
  assign compare_unit1_output = t[2];
  assign compare_unit2_output = ~t[1];
  // pad level: the port when it drives, else the board
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  assign test_pin = sess;
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic mclk, nrst, psel, penable, pwrite, tpa, sess, intact, err;
  logic pready, pslverr, alt, cap, irq, sense, aux, cmp, c1, c2, tpin;
  logic [7:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rdv;
  logic [5:0] pin_in, pin_out, pin_oe, ext;
  int m[8];
  int num_errors, n_checks, seed, b;
  int cyc = 0;

  port2_pin_function_mux port2_pin_function_mux_i (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .aux_clock(aux), .comparator_result(cmp), .compare_unit1_output(c1),
    .compare_unit2_output(c2), .timer_alternate_clock_in(alt), .capture0_source_b(cap),
    .irq_request(irq), .test_port_access(tpa), .test_pin(tpin), .fuse_intact(intact),
    .fuse_sense_en(sense));
  port2_far port2_far_i (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
    .sess(sess), .pin_in(pin_in), .aux_clock(aux), .comparator_result(cmp),
    .compare_unit1_output(c1), .compare_unit2_output(c2), .test_pin(tpin));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; waits on pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // input value and fuse status are read-only, so the model keeps them
  task automatic wr(input int a, input int d);
    apb(1'b1, a[7:0], d[7:0]);
    if (a != 12 && a != 28) m[a/4] = d & 255;
  endtask

  task automatic rd(input int a, input int e);
    apb(1'b0, a[7:0], 8'h00);
    chk($sformatf("reg %0h", a), e, rdv);
  endtask

  function automatic logic [5:0] exp_out();
    logic [5:0] p;
    p = {1'b0, c2, c1, cmp, 1'b0, aux};
    return (m[0][5:0] & p) | (~m[0][5:0] & m[2][5:0]);
  endfunction

  initial begin
    {psel, penable, pwrite, tpa, sess, nrst} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    intact = 1'b1;
    ext = 6'h00;
    seed = 40182;
    foreach (m[i]) m[i] = 0;
    m[7] = 1;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (b = 0; b < 8; b++) rd(b * 4, m[b]);
    apb(1'b0, 8'h20, 8'h00);
    chk("slverr", 1, err);
    chk("unmapped", 0, rdv);
    $display("test reset done");
    for (b = 0; b < 8; b++) if (b != 1) wr(b * 4, $random(seed));
    for (b = 0; b < 8; b++) rd(b * 4, m[b]);
    chk("irq", |(m[4] & m[5]), irq);
    $display("test registers done");
    wr(4, 8'hff);
    wr(0, 8'hff);
    wr(8, $random(seed));
    repeat (4) begin
      @(negedge mclk);
      chk("pin_out", exp_out(), pin_out);
    end
    chk("pin_oe", m[1][5:0], pin_oe);
    wr(0, 8'h00);
    @(negedge mclk);
    chk("latch", exp_out(), pin_out);
    wr(4, 8'h00);
    wr(0, 8'h06);
    for (b = 0; b < 4; b++) begin
      ext <= 6'(b * 2);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("alt", ext[1], alt);
      chk("cap", ext[2], cap);
      @(posedge mclk);
    end
    $display("test mux done");
    wr(0, 8'h00);
    wr(16, 8'hff);
    wr(24, $random(seed));
    ext <= m[6][5:0];
    repeat (4) @(posedge mclk);
    wr(20, 8'h00);
    for (b = 0; b < 6; b++) begin
      ext[b] <= ~ext[b];
      repeat (4) @(posedge mclk);
      m[5] = 1 << b;
      rd(20, m[5]);
      chk("irq", 1, irq);
      ext[b] <= ~ext[b];
      repeat (4) @(posedge mclk);
      rd(20, m[5]);
      wr(20, 8'h00);
      @(negedge mclk);
      chk("irq", 0, irq);
      @(posedge mclk);
    end
    wr(20, 8'hc0);
    wr(16, 8'h80);
    @(negedge mclk);
    chk("irq", 1, irq);
    wr(16, 8'h00);
    rd(20, 8'hc0);
    $display("test flags done");
    sess <= 1'b1;
    repeat (3) @(posedge mclk);
    tpa <= 1'b1;
    @(posedge mclk);
    tpa <= 1'b0;
    @(negedge mclk);
    chk("sense", 1, sense);
    rd(28, 6);
    sess <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("sense", 0, sense);
    @(posedge mclk);
    sess <= 1'b1;
    repeat (3) @(posedge mclk);
    tpa <= 1'b1;
    @(posedge mclk);
    tpa <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("sense", 0, sense);
    rd(28, 0);
    // a fresh reset arms the check again and must not invent pin edges
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd(28, 1);
    rd(20, 0);
    tpa <= 1'b1;
    @(posedge mclk);
    tpa <= 1'b0;
    @(negedge mclk);
    chk("sense", 1, sense);
    $display("test fuse done");
    wrap_up();
  end
endmodule

`default_nettype wire
